// [hdl/cas_pkg.sv]
// Shared constants, opcodes and state codes for the core ALU and sleep block
//==============================================================================
package cas_pkg;

  //==========================================================================
  // Widths and field positions
  localparam int unsigned CAS_DATA_W      = 8;
  localparam int unsigned CAS_ADDR_W      = 7;
  localparam int unsigned CAS_BUS_ADDR_W  = 4;
  localparam int unsigned CAS_MSB         = 7;
  localparam int unsigned CAS_LSB         = 0;
  localparam int unsigned CAS_NIB_LO_MSB  = 3;
  localparam int unsigned CAS_NIB_HI_LSB  = 4;
  localparam logic [6:0]  CAS_FILE_ADDR_MAX = 7'h7F;

  // Destination select
  localparam logic CAS_DEST_WORK = 1'b0;
  localparam logic CAS_DEST_FILE = 1'b1;

  //==========================================================================
  // Values and reset values
  localparam logic [7:0] CAS_ZERO_BYTE          = 8'h00;
  localparam logic [7:0] CAS_WATCHDOG_CLEAR     = 8'h00;
  localparam logic [7:0] CAS_PRESCALE_CLEAR     = 8'h00;
  localparam logic [7:0] CAS_WORK_RST           = 8'h00;
  localparam logic       CAS_FLAG_RST           = 1'b0;
  localparam logic       CAS_TIMEOUT_N_RST      = 1'b1;
  localparam logic       CAS_POWER_DOWN_N_RST   = 1'b1;
  localparam logic       CAS_TIMEOUT_N_SLEEP    = 1'b1;
  localparam logic       CAS_POWER_DOWN_N_SLEEP = 1'b0;

  //==========================================================================
  // Status register bit positions
  localparam int unsigned CAS_ST_CARRY       = 0;
  localparam int unsigned CAS_ST_HALF_CARRY  = 1;
  localparam int unsigned CAS_ST_ZERO        = 2;
  localparam int unsigned CAS_ST_POWER_DOWN  = 3;
  localparam int unsigned CAS_ST_TIMEOUT     = 4;
  localparam int unsigned CAS_ST_SLEEP       = 5;

  // Register offsets
  localparam logic [3:0] CAS_REG_STATUS   = 4'h0;
  localparam logic [3:0] CAS_REG_WORK     = 4'h1;
  localparam logic [3:0] CAS_REG_WATCHDOG = 4'h2;
  localparam logic [3:0] CAS_REG_PRESCALE = 4'h3;

  //==========================================================================
  // Timing
  localparam int unsigned CAS_CLK_PERIOD_NS  = 100;
  localparam int unsigned CAS_WD_TICK_NS     = 1000;
  localparam int unsigned CAS_WD_TICK_CYCLES =
    (CAS_WD_TICK_NS / CAS_CLK_PERIOD_NS < 1) ? 1 : CAS_WD_TICK_NS / CAS_CLK_PERIOD_NS;

  //==========================================================================
  // Opcodes and core states
  typedef enum logic [2:0] {
    CAS_OP_NONE               = 3'h0,
    CAS_OP_ROTATE_RIGHT_CARRY = 3'h1,
    CAS_OP_LITERAL_MINUS_WORK = 3'h2,
    CAS_OP_FILE_MINUS_WORK    = 3'h3,
    CAS_OP_XOR_WORK_FILE      = 3'h4,
    CAS_OP_XOR_LITERAL        = 3'h5,
    CAS_OP_NIBBLE_EXCHANGE    = 3'h6,
    CAS_OP_SLEEP              = 3'h7
  } cas_op_t;

  typedef enum logic [1:0] {
    CAS_STATE_RUN  = 2'b01,
    CAS_STATE_HALT = 2'b10
  } cas_state_t;

endpackage : cas_pkg

// [hdl/cas_watchdog.sv]
// Watchdog prescaler and counter with synchronous clear
`timescale 1ns/1ps
module cas_watchdog
  import cas_pkg::*;
#(
  parameter int unsigned PRE_W = 8,
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             i_clk,      // Core clock
  input  wire logic             i_reset,    // Async reset, active high
  input  wire logic             i_tick,     // One-cycle count enable
  input  wire logic             i_clear,    // Clear counter and prescaler
  output logic [PRE_W-1:0]      o_prescale, // Prescaler value
  output logic [CNT_W-1:0]      o_count     // Watchdog counter value
);

  //============================================================================
  // Prescaler carry
  logic pre_wrap;
  assign pre_wrap = i_tick && (&o_prescale);

  // Prescaler: clear takes priority so a sleep never loses the restart
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prescale <= '0;
    end else if (i_clear) begin
      o_prescale <= CAS_PRESCALE_CLEAR[PRE_W-1:0];
    end else if (i_tick) begin
      o_prescale <= o_prescale + 1'b1;
    end
  end

  // Counter advances once per prescaler wrap and simply rolls over
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= CAS_WATCHDOG_CLEAR[CNT_W-1:0];
    end else if (pre_wrap) begin
      o_count <= o_count + 1'b1;
    end
  end

endmodule : cas_watchdog

// [hdl/cas_alu_top.sv]
// Core ALU subset with sleep handling, status flags and register port
`timescale 1ns/1ps
module cas_alu_top
  import cas_pkg::*;
#(
  parameter int unsigned WD_TICK_CYCLES = CAS_WD_TICK_CYCLES
) (
  input  wire logic        I_REF_CLK,          // Core clock, 10 MHz
  input  wire logic        I_RESET,            // Async reset, active high
  input  wire logic        I_OP_VALID,         // One-cycle instruction strobe
  input  wire logic [2:0]  I_OP_CODE,          // Instruction code
  input  wire logic [6:0]  I_FILE_ADDR,        // File register address
  input  wire logic        I_DEST,             // Destination bit
  input  wire logic [7:0]  I_LITERAL,          // Eight-bit literal
  input  wire logic [7:0]  I_FILE_DATA,        // Addressed file value
  input  wire logic [3:0]  I_BUS_ADDR,         // Register port address
  input  wire logic [7:0]  I_BUS_WDATA,        // Register port write data
  input  wire logic        I_BUS_WR,           // Register write strobe
  input  wire logic        I_BUS_RD,           // Register read strobe
  output logic [7:0]       O_BUS_RDATA,        // Read data, cycle after strobe
  output logic             O_FILE_WE,          // File write-back pulse
  output logic [6:0]       O_FILE_ADDR,        // File write-back address
  output logic [7:0]       O_FILE_WDATA,       // File write-back data
  output logic [7:0]       O_WORK,             // Working register
  output logic             O_CARRY,            // Carry flag
  output logic             O_HALF_CARRY,       // Half carry flag
  output logic             O_ZERO,             // Zero flag
  output logic             O_TIMEOUT_FLAG_N,   // Timeout flag, active low
  output logic             O_POWER_DOWN_FLAG_N,// Power-down flag, active low
  output logic             O_SLEEP,            // Core halted in sleep
  output logic             O_OSC_RUN,          // Oscillator enable
  output logic             O_DONE              // Instruction retired pulse
);

  //============================================================================
  // Declarations
  cas_state_t  state_reg;
  cas_op_t     op;
  logic        take;
  logic [7:0]  res_next;
  logic        carry_next;
  logic        half_next;
  logic        upd_carry;
  logic        upd_half;
  logic        upd_zero;
  logic        to_work;
  logic        to_file;
  logic [8:0]  diff;
  logic [7:0]  minuend;
  logic        sleep_go;
  logic [7:0]  prescale;
  logic [7:0]  wd_count;
  logic        tick;
  logic [15:0] div_reg;

  assign op       = cas_op_t'(I_OP_CODE);
  // Halted core ignores any instruction strobe; only reset brings it back
  assign take     = I_OP_VALID && (state_reg == CAS_STATE_RUN);
  assign sleep_go = take && (op == CAS_OP_SLEEP);

  //============================================================================
  // Result and flag computation
  assign minuend = (op == CAS_OP_LITERAL_MINUS_WORK) ? I_LITERAL : I_FILE_DATA;
  // Nine bits keep the borrow; carry is its inverse
  assign diff    = {1'b0, minuend} - {1'b0, O_WORK};

  always_comb begin
    res_next   = CAS_ZERO_BYTE;
    carry_next = O_CARRY;
    half_next  = O_HALF_CARRY;
    upd_carry  = 1'b0;
    upd_half   = 1'b0;
    upd_zero   = 1'b0;
    to_work    = 1'b0;
    to_file    = 1'b0;
    case (op)
      CAS_OP_ROTATE_RIGHT_CARRY: begin
        res_next   = {O_CARRY, I_FILE_DATA[CAS_MSB:CAS_LSB+1]};
        carry_next = I_FILE_DATA[CAS_LSB];
        upd_carry  = 1'b1;
        to_work    = (I_DEST == CAS_DEST_WORK);
        to_file    = (I_DEST == CAS_DEST_FILE);
      end
      CAS_OP_LITERAL_MINUS_WORK: begin
        res_next   = diff[CAS_MSB:CAS_LSB];
        carry_next = ~diff[CAS_DATA_W];
        half_next  = (O_WORK[CAS_NIB_LO_MSB:0] <= I_LITERAL[CAS_NIB_LO_MSB:0]);
        upd_carry  = 1'b1;
        upd_half   = 1'b1;
        upd_zero   = 1'b1;
        to_work    = 1'b1;
      end
      CAS_OP_FILE_MINUS_WORK: begin
        res_next   = diff[CAS_MSB:CAS_LSB];
        carry_next = ~diff[CAS_DATA_W];
        half_next  = (O_WORK[CAS_NIB_LO_MSB:0] <= I_FILE_DATA[CAS_NIB_LO_MSB:0]);
        upd_carry  = 1'b1;
        upd_half   = 1'b1;
        upd_zero   = 1'b1;
        to_work    = (I_DEST == CAS_DEST_WORK);
        to_file    = (I_DEST == CAS_DEST_FILE);
      end
      CAS_OP_XOR_WORK_FILE: begin
        res_next = O_WORK ^ I_FILE_DATA;
        upd_zero = 1'b1;
        to_work  = (I_DEST == CAS_DEST_WORK);
        to_file  = (I_DEST == CAS_DEST_FILE);
      end
      CAS_OP_XOR_LITERAL: begin
        res_next = O_WORK ^ I_LITERAL;
        upd_zero = 1'b1;
        to_work  = 1'b1;
      end
      CAS_OP_NIBBLE_EXCHANGE: begin
        res_next = {I_FILE_DATA[CAS_NIB_LO_MSB:0], I_FILE_DATA[CAS_MSB:CAS_NIB_HI_LSB]};
        to_work  = (I_DEST == CAS_DEST_WORK);
        to_file  = (I_DEST == CAS_DEST_FILE);
      end
      default: begin
        res_next = CAS_ZERO_BYTE;
      end
    endcase
  end

  //============================================================================
  // Working register: instruction result wins over a software write
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_WORK <= CAS_WORK_RST;
    end else if (take && to_work) begin
      O_WORK <= res_next;
    end else if (I_BUS_WR && (I_BUS_ADDR == CAS_REG_WORK)) begin
      O_WORK <= I_BUS_WDATA;
    end
  end

  // File write-back: one pulse, data held until the next write-back
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_FILE_WE    <= 1'b0;
      O_FILE_ADDR  <= '0;
      O_FILE_WDATA <= CAS_ZERO_BYTE;
    end else begin
      O_FILE_WE <= take && to_file;
      if (take && to_file) begin
        O_FILE_ADDR  <= I_FILE_ADDR & CAS_FILE_ADDR_MAX;
        O_FILE_WDATA <= res_next;
      end
    end
  end

  //============================================================================
  // Arithmetic flags: instruction update wins over a software write
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CARRY      <= CAS_FLAG_RST;
      O_HALF_CARRY <= CAS_FLAG_RST;
      O_ZERO       <= CAS_FLAG_RST;
    end else if (take && (upd_carry || upd_zero)) begin
      if (upd_carry) begin
        O_CARRY <= carry_next;
      end
      if (upd_half) begin
        O_HALF_CARRY <= half_next;
      end
      if (upd_zero) begin
        O_ZERO <= (res_next == CAS_ZERO_BYTE);
      end
    end else if (I_BUS_WR && (I_BUS_ADDR == CAS_REG_STATUS)) begin
      O_CARRY      <= I_BUS_WDATA[CAS_ST_CARRY];
      O_HALF_CARRY <= I_BUS_WDATA[CAS_ST_HALF_CARRY];
      O_ZERO       <= I_BUS_WDATA[CAS_ST_ZERO];
    end
  end

  //============================================================================
  // Sleep status bits
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_TIMEOUT_FLAG_N    <= CAS_TIMEOUT_N_RST;
      O_POWER_DOWN_FLAG_N <= CAS_POWER_DOWN_N_RST;
    end else if (sleep_go) begin
      O_TIMEOUT_FLAG_N    <= CAS_TIMEOUT_N_SLEEP;
      O_POWER_DOWN_FLAG_N <= CAS_POWER_DOWN_N_SLEEP;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= CAS_STATE_RUN;
    end else begin
      case (state_reg)
        CAS_STATE_RUN: begin
          if (sleep_go) begin
            state_reg <= CAS_STATE_HALT;
          end
        end
        CAS_STATE_HALT: begin
          state_reg <= CAS_STATE_HALT;
        end
        default: begin
          state_reg <= CAS_STATE_RUN;
        end
      endcase
    end
  end

  assign O_SLEEP   = (state_reg == CAS_STATE_HALT);
  assign O_OSC_RUN = (state_reg == CAS_STATE_RUN);

  // Retire pulse for every accepted instruction except code zero (CAS_OP_NONE)
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_DONE <= 1'b0;
    end else begin
      O_DONE <= take && (op != CAS_OP_NONE);
    end
  end

  //============================================================================
  // Watchdog tick divider; it keeps running in sleep because the watchdog
  // has a clock source of its own, which this divider stands in for
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      div_reg <= '0;
    end else if (div_reg >= 16'(WD_TICK_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  assign tick = (div_reg >= 16'(WD_TICK_CYCLES - 1));

  cas_watchdog #(
    .PRE_W (CAS_DATA_W),
    .CNT_W (CAS_DATA_W)
  ) u_watchdog (
    .i_clk      (I_REF_CLK),
    .i_reset    (I_RESET),
    .i_tick     (tick),
    .i_clear    (sleep_go),
    .o_prescale (prescale),
    .o_count    (wd_count)
  );

  //============================================================================
  // Register read port, data valid the cycle after the strobe only
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_BUS_RDATA <= CAS_ZERO_BYTE;
    end else if (!I_BUS_RD) begin
      O_BUS_RDATA <= CAS_ZERO_BYTE;
    end else if (I_BUS_ADDR == CAS_REG_STATUS) begin
      O_BUS_RDATA <= {2'b00, O_SLEEP, O_TIMEOUT_FLAG_N, O_POWER_DOWN_FLAG_N,
                      O_ZERO, O_HALF_CARRY, O_CARRY};
    end else if (I_BUS_ADDR == CAS_REG_WORK) begin
      O_BUS_RDATA <= O_WORK;
    end else if (I_BUS_ADDR == CAS_REG_WATCHDOG) begin
      O_BUS_RDATA <= wd_count;
    end else if (I_BUS_ADDR == CAS_REG_PRESCALE) begin
      O_BUS_RDATA <= prescale;
    end else begin
      O_BUS_RDATA <= CAS_ZERO_BYTE;
    end
  end

  //============================================================================
  // Checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  property p_wd_clear;
    sleep_go |=> (wd_count == CAS_WATCHDOG_CLEAR) && (prescale == CAS_PRESCALE_CLEAR);
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("watchdog not cleared by sleep");

  property p_sleep_flags;
    sleep_go |=> O_TIMEOUT_FLAG_N && !O_POWER_DOWN_FLAG_N && $stable(O_CARRY)
      && $stable(O_ZERO) && $stable(O_HALF_CARRY);
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep status bits wrong");

  property p_halt;
    sleep_go |=> (O_SLEEP && !O_OSC_RUN)[*4];
  endproperty
  a_halt: assert property (p_halt)
    else $error("core did not stay halted");

  property p_rotate;
    (take && op == CAS_OP_ROTATE_RIGHT_CARRY && I_DEST == CAS_DEST_FILE) |=>
      O_FILE_WE && O_FILE_WDATA == {$past(O_CARRY), $past(I_FILE_DATA[7:1])}
      && O_CARRY == $past(I_FILE_DATA[0]) && $stable(O_ZERO);
  endproperty
  a_rotate: assert property (p_rotate)
    else $error("rotate result wrong");

  property p_dest_work;
    (take && to_work && !to_file) |=> !O_FILE_WE && O_WORK == $past(res_next);
  endproperty
  a_dest_work: assert property (p_dest_work)
    else $error("result not steered to work");

  property p_lit_sub;
    (take && op == CAS_OP_LITERAL_MINUS_WORK) |=>
      O_WORK == 8'($past(I_LITERAL) - $past(O_WORK))
      && O_CARRY == ($past(O_WORK) <= $past(I_LITERAL));
  endproperty
  a_lit_sub: assert property (p_lit_sub)
    else $error("literal subtract wrong");

  property p_file_sub;
    (take && op == CAS_OP_FILE_MINUS_WORK) |=>
      O_CARRY == ($past(O_WORK) <= $past(I_FILE_DATA))
      && O_HALF_CARRY == ($past(O_WORK[3:0]) <= $past(I_FILE_DATA[3:0]));
  endproperty
  a_file_sub: assert property (p_file_sub)
    else $error("file subtract flags wrong");

  property p_xor_file;
    (take && op == CAS_OP_XOR_WORK_FILE) |=> $stable(O_CARRY) && $stable(O_HALF_CARRY);
  endproperty
  a_xor_file: assert property (p_xor_file)
    else $error("xor with file touched carry");

  property p_nibble;
    (take && op == CAS_OP_NIBBLE_EXCHANGE && I_DEST == CAS_DEST_FILE) |=>
      O_FILE_WDATA == {$past(I_FILE_DATA[3:0]), $past(I_FILE_DATA[7:4])} && $stable(O_ZERO);
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("nibble exchange wrong");

  property p_xor_lit;
    (take && op == CAS_OP_XOR_LITERAL) |=> O_WORK == ($past(O_WORK) ^ $past(I_LITERAL));
  endproperty
  a_xor_lit: assert property (p_xor_lit)
    else $error("xor with literal wrong");

  property p_zero;
    (take && upd_zero) |=> O_ZERO == ($past(res_next) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

endmodule : cas_alu_top

// [test/cas_file_model.sv]
// Partner model: file register memory read by the decoder side and written back by the block
`timescale 1ns/1ps
module cas_file_model (
  input  wire logic       i_clk,   // Core clock
  input  wire logic [6:0] i_addr,  // Addressed file register
  input  wire logic       i_we,    // Write-back pulse from the block
  input  wire logic [6:0] i_waddr, // Write-back address
  input  wire logic [7:0] i_wdata, // Write-back data
  output logic      [7:0] o_rdata  // Addressed file value
);
  logic [7:0] mem [128];
  //============================================================================
  // Storage
  // Distinct seed per address so a wrong address shows up as a wrong value
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 90);
    end
  end
  // Write-back lands at the edge that sees the pulse, as a real file would
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end
  // Read is combinational so the value is valid in the strobe cycle
  assign o_rdata = mem[i_addr];
endmodule : cas_file_model

// [test/cas_alu_top_tb.sv]
// Self-checking testbench for the core ALU subset and sleep handling
`timescale 1ns/1ps
module cas_alu_top_tb;
  import cas_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, op_valid = 1'b0, dest = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [6:0] file_addr = 7'h00, file_waddr;
  logic [7:0] literal = 8'h00, file_data, bus_wdata = 8'h00, rdata, file_wdata, work;
  logic [3:0] bus_addr = 4'h0;
  logic       file_we, carry, hc, zero, to_n, pd_n, sleep, osc, done;
  int         n_errors = 0, checks = 0;

  //============================================================================
  // Clock, design and partner
  always #50 clk = ~clk;
  cas_alu_top #(.WD_TICK_CYCLES(1)) uut (.I_REF_CLK(clk), .I_RESET(rst), .I_OP_VALID(op_valid),
    .I_OP_CODE(op_code), .I_FILE_ADDR(file_addr), .I_DEST(dest), .I_LITERAL(literal),
    .I_FILE_DATA(file_data), .I_BUS_ADDR(bus_addr), .I_BUS_WDATA(bus_wdata), .I_BUS_WR(bus_wr),
    .I_BUS_RD(bus_rd), .O_BUS_RDATA(rdata), .O_FILE_WE(file_we), .O_FILE_ADDR(file_waddr),
    .O_FILE_WDATA(file_wdata), .O_WORK(work), .O_CARRY(carry), .O_HALF_CARRY(hc), .O_ZERO(zero),
    .O_TIMEOUT_FLAG_N(to_n), .O_POWER_DOWN_FLAG_N(pd_n), .O_SLEEP(sleep), .O_OSC_RUN(osc),
    .O_DONE(done));
  cas_file_model fmod (.i_clk(clk), .i_addr(file_addr), .i_we(file_we), .i_waddr(file_waddr),
    .i_wdata(file_wdata), .o_rdata(file_data));

  //============================================================================
  // Shared tasks
  task automatic complete_run;
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8
  // Strobe held for exactly one cycle; results are settled 1 ns after the taking edge
  task automatic run_op(input cas_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= op;
    file_addr <= a;
    dest <= d;
    literal <= k;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : run_op
  task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = rdata;
  endtask : bus_read
  // Destination steering: either work changes or a write-back pulse goes out, never both
  task automatic chk_dest(input logic d, input logic [6:0] a, input logic [7:0] r,
                          input logic [7:0] w_old);
    chk8({7'h00, done}, 8'h01, "done");
    chk8({7'h00, file_we}, {7'h00, d}, "write-back pulse");
    chk8(work, d ? w_old : r, "work");
    if (d) begin
      chk8(file_wdata, r, "write-back data");
      chk8({1'b0, file_waddr}, {1'b0, a}, "write-back address");
    end
  endtask : chk_dest

  //============================================================================
  // Scenarios
  task automatic t_subtract;
    logic [7:0] lw [4] = '{8'h20, 8'h21, 8'h0F, 8'h00};
    logic [7:0] la [4] = '{8'h20, 8'h20, 8'h10, 8'hFF};
    logic [7:0] a, w, r;
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? la[i % 4] : fmod.mem[i];
      w = (i == 4) ? a : lw[i % 4];
      r = a - w;
      bus_write(CAS_REG_WORK, w);
      run_op((i < 4) ? CAS_OP_LITERAL_MINUS_WORK : CAS_OP_FILE_MINUS_WORK, 7'(i), i[0], a);
      chk_dest((i < 4) ? 1'b0 : i[0], 7'(i), r, w);
      chk8({5'h00, carry, hc, zero},
           {5'h00, w <= a, w[3:0] <= a[3:0], r == 8'h00}, "sub flags");
    end
  endtask : t_subtract
  task automatic t_rotate_swap;
    logic [7:0] f, r;
    for (int i = 0; i < 4; i++) begin
      f = fmod.mem[7'h7F - i];
      bus_write(CAS_REG_STATUS, {5'h00, 1'b1, 1'b1, i[1]});
      bus_write(CAS_REG_WORK, 8'hA5);
      run_op(i[1] ? CAS_OP_NIBBLE_EXCHANGE : CAS_OP_ROTATE_RIGHT_CARRY, 7'h7F - i, i[0], 8'h00);
      r = i[1] ? {f[3:0], f[7:4]} : {i[1], f[7:1]};
      chk_dest(i[0], 7'h7F - i, r, 8'hA5);
      chk8({5'h00, carry, hc, zero},
           {5'h00, i[1] ? 1'b1 : f[0], 2'b11}, "shift flags");
      @(posedge clk);
      #1 chk8(fmod.mem[7'h7F - i], i[0] ? r : f, "file contents");
    end
  endtask : t_rotate_swap
  task automatic t_xor;
    logic [7:0] f, r;
    for (int i = 0; i < 4; i++) begin
      f = fmod.mem[7'h30 + i];
      r = (i[1] ? f : 8'h3C) ^ f;
      // Zero preset opposite to the expected result so every pass must move it
      bus_write(CAS_REG_STATUS, {5'h00, r != 8'h00, 2'b10});
      bus_write(CAS_REG_WORK, i[1] ? f : 8'h3C);
      run_op(i[0] ? CAS_OP_XOR_LITERAL : CAS_OP_XOR_WORK_FILE, 7'h30 + i, 1'b1, f);
      chk_dest(i[0] ? 1'b0 : 1'b1, 7'h30 + i, r, i[1] ? f : 8'h3C);
      chk8({5'h00, carry, hc, zero},
           {5'h00, 2'b01, r == 8'h00}, "xor flags");
    end
  endtask : t_xor
  task automatic t_sleep;
    logic [7:0] v;
    repeat (300) @(posedge clk);
    bus_read(CAS_REG_WATCHDOG, v);
    chk8({7'h00, v != 8'h00}, 8'h01, "watchdog running");
    bus_write(CAS_REG_STATUS, 8'h05);
    bus_write(CAS_REG_WORK, 8'h66);
    // Code zero must retire nothing and leave work and flags alone
    run_op(CAS_OP_NONE, 7'h05, 1'b1, 8'hFF);
    chk8({6'h00, done, file_we}, 8'h00, "code zero idle");
    run_op(CAS_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    chk8({4'h0, done, sleep, osc, file_we}, 8'h0C, "sleep entry");
    chk8({6'h00, to_n, pd_n}, 8'h02, "sleep status");
    chk8({work[3:0], 1'b0, carry, hc, zero}, 8'h65, "other state kept");
    bus_read(CAS_REG_WATCHDOG, v);
    chk8(v, CAS_WATCHDOG_CLEAR, "watchdog cleared");
    bus_read(CAS_REG_PRESCALE, v);
    chk8({7'h00, v < 8'h08}, 8'h01, "prescaler cleared");
    bus_read(CAS_REG_STATUS, v);
    chk8(v, 8'h35, "status register");
    run_op(CAS_OP_XOR_LITERAL, 7'h00, 1'b0, 8'hFF);
    chk8({done, sleep, osc, 5'h00}, 8'h40, "halted ignores op");
    chk8(work, 8'h66, "work held in sleep");
    bus_read(4'hF, v);
    chk8(v, 8'h00, "unmapped read");
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1 chk8({4'h0, sleep, osc, to_n, pd_n}, 8'h07, "reset leaves sleep");
  endtask : t_sleep

  //============================================================================
  // Main sequence and hang guard
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk8({4'h0, sleep, osc, to_n, pd_n}, 8'h07, "reset state");
    t_subtract();
    t_rotate_swap();
    t_xor();
    t_sleep();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule : cas_alu_top_tb
